// file: rtl/fnsc_defs.vh
`ifndef FNSC_DEFS_VH
`define FNSC_DEFS_VH
`define FNSC_A_ENABLE 15'h0103
`define FNSC_A_INT_L 15'h0200
`define FNSC_A_INT_H 15'h0201
`define FNSC_A_FRAC_L 15'h0202
`define FNSC_A_FRAC_M 15'h0203
`define FNSC_A_FRAC_H 15'h0204
`define FNSC_A_DEN_L 15'h0208
`define FNSC_A_DEN_M 15'h0209
`define FNSC_A_DEN_H 15'h020a
`define FNSC_A_RDIV_L 15'h020c
`define FNSC_A_RDIV_H 15'h020d
`define FNSC_A_REFCFG 15'h020e
`define FNSC_A_MUXSEL 15'h0213
`define FNSC_A_LOCK 15'h0214
`define FNSC_A_PUMP 15'h022e
`define FNSC_A_BLEED 15'h022f
`define FNSC_RST_ENABLE 8'h6f
`define FNSC_RST_INT_L 8'ha7
`define FNSC_RST_INT_H 8'h00
`define FNSC_RST_FRAC_L 8'h02
`define FNSC_RST_DEN_L 8'h04
`define FNSC_RST_RDIV_L 8'h01
`define FNSC_RST_PUMP 8'h03
`define FNSC_RST_LOCK 8'h00
`define FNSC_ENABLE_RSVD_MASK 8'h90
`define FNSC_INT_MIN 16'h004b
`define FNSC_LOCK_COUNT 8192
`define FNSC_FRAME_BITS 24
`define FNSC_POST_CLKS 5'd16
`define FNSC_MUX_LOW 8'h00
`define FNSC_MUX_HIGH 8'h01
`define FNSC_MUX_LOCK 8'h02
`define FNSC_MUX_RCLK 8'h03
`define FNSC_MUX_NCLK 8'h04
`endif

// file: rtl/fnsc_lock_detect.v
/*
 Digital lock detector: counts consecutive in-window comparison cycles.
 Assumes i_cmp_tick and i_in_window are synchronous to i_clk.
*/
`timescale 1ns/1ns
module fnsc_lock_detect #(
	parameter CNT_W = 14,
	parameter LOCK_COUNT = 8192
) (
	input wire i_clk,
	input wire i_rst,
	input wire i_enable,
	input wire i_cmp_tick,
	input wire i_in_window,
	output reg o_locked
);
	reg [CNT_W-1:0] cnt_r;
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_r <= {CNT_W{1'b0}};
			o_locked <= 1'b0;
		end else if (!i_enable) begin
			cnt_r <= {CNT_W{1'b0}};
			o_locked <= 1'b0;
		end else if (i_cmp_tick) begin
			if (!i_in_window) begin
				cnt_r <= {CNT_W{1'b0}};
				o_locked <= 1'b0;
			end else if (cnt_r == LOCK_COUNT[CNT_W-1:0] - 1'b1) begin
				o_locked <= 1'b1;
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end
endmodule

// file: rtl/fnsc_top.v
/*
 Serial control port and register file of the fractional-N synthesizer.
 Assumes SCLK, SDI and chip select are synchronous to i_clk and slower.
*/
// Functional notes
// - Feedback ratio integer plus fraction over denominator
// - Fraction numerator held as 24 bits
// - Denominator 24 bits, zero never legal
// - Zero fraction selects integer-only mode
// - Comparison clock from doubler, divider, halver
// - Oscillator from comparison times ratio, LO doubled
// - Pump current code four bits at 0x22e
// - Pump current code resets to three
// - Bleed code eight bits at 0x22f
// - Status pin shows signal chosen by select
// - Lock after programmed consecutive in-window cycles; count here is the LOCK_COUNT parameter, register 0x214 is only stored
// - Zero enables disable all; bits 4,7 zero
// - Frame: direction, 15 address, 8 data MSB-first
// - Write bits sampled on rising SCLK
// - Divider settings in 0x200 through 0x20a
// - Low integer write applies buffers, starts calibration
// - Read data shifted out on falling SCLK
// - Serial output released while chip select high
`timescale 1ns/1ns
`include "fnsc_defs.vh"
module fnsc_top #(
	parameter LOCK_COUNT = `FNSC_LOCK_COUNT,
	parameter LOCK_CNT_W = 14
) (
	input wire i_clk,
	input wire i_rst,
	input wire i_sclk,
	input wire i_sdi,
	input wire i_cs_n,
	input wire i_cmp_tick,
	input wire i_in_window,
	input wire i_ref_clk_div,
	input wire i_fb_clk_div,
	output reg o_sdo,
	output reg o_sdo_oe,
	output reg o_status_output_pin,
	output reg [15:0] o_int_value,
	output reg [23:0] o_frac_value,
	output reg [23:0] o_divider_denominator,
	output reg o_integer_mode,
	output reg [9:0] o_ref_div,
	output reg o_ref_double,
	output reg o_ref_half,
	output reg [3:0] o_pump_current_code,
	output reg [7:0] o_bleed_current_code,
	output reg [7:0] o_block_enable,
	output reg o_autocal_start
);
	// Serial port state
	reg sclk_d_r;
	reg [4:0] bit_cnt_r;
	reg [23:0] shift_r;
	reg [7:0] rd_shift_r;
	reg reading_r;
	reg [4:0] post_cnt_r;
	// Shadow registers; feedback divider and pump values act on the low integer write
	reg [7:0] enable_r;
	reg [7:0] int_l_r;
	reg [7:0] int_h_r;
	reg [7:0] frac_l_r;
	reg [7:0] frac_m_r;
	reg [7:0] frac_h_r;
	reg [7:0] den_l_r;
	reg [7:0] den_m_r;
	reg [7:0] den_h_r;
	reg [7:0] rdiv_l_r;
	reg [7:0] rdiv_h_r;
	reg [7:0] refcfg_r;
	reg [7:0] muxsel_r;
	reg [7:0] lock_r;
	reg [7:0] pump_r;
	reg [7:0] bleed_r;
	// Read-back word and status mux value
	reg [7:0] rd_data;
	reg status_nxt;
	// SCLK edges found by oversampling; each SCLK level must last at least one clock
	wire rise = i_sclk & ~sclk_d_r & ~i_cs_n;
	wire fall = ~i_sclk & sclk_d_r & ~i_cs_n;
	wire [23:0] frame = {shift_r[22:0], i_sdi};
	wire [14:0] addr = frame[22:8];
	// A write lands on the 24th rising edge
	wire last_bit = rise && bit_cnt_r == 5'd23;
	wire wr = last_bit && !frame[23];
	wire locked;

	function [7:0] sel;
		input [14:0] a;
		input [14:0] b;
		input [7:0] v;
		sel = (a == b) ? v : 8'h00;
	endfunction

	// The address is complete on the 16th rising edge, before it reaches shift_r
	always @* begin
		rd_data = sel(frame[14:0], `FNSC_A_ENABLE, enable_r)
			| sel(frame[14:0], `FNSC_A_INT_L, int_l_r)
			| sel(frame[14:0], `FNSC_A_INT_H, int_h_r)
			| sel(frame[14:0], `FNSC_A_FRAC_L, frac_l_r)
			| sel(frame[14:0], `FNSC_A_FRAC_M, frac_m_r)
			| sel(frame[14:0], `FNSC_A_FRAC_H, frac_h_r)
			| sel(frame[14:0], `FNSC_A_DEN_L, den_l_r)
			| sel(frame[14:0], `FNSC_A_DEN_M, den_m_r)
			| sel(frame[14:0], `FNSC_A_DEN_H, den_h_r)
			| sel(frame[14:0], `FNSC_A_RDIV_L, rdiv_l_r)
			| sel(frame[14:0], `FNSC_A_RDIV_H, rdiv_h_r)
			| sel(frame[14:0], `FNSC_A_REFCFG, refcfg_r)
			| sel(frame[14:0], `FNSC_A_MUXSEL, muxsel_r)
			| sel(frame[14:0], `FNSC_A_LOCK, lock_r)
			| sel(frame[14:0], `FNSC_A_PUMP, pump_r)
			| sel(frame[14:0], `FNSC_A_BLEED, bleed_r);
	end

	// Serial input shifter; a frame cut short just leaves the counter reset
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sclk_d_r <= 1'b0;
			bit_cnt_r <= 5'd0;
			shift_r <= 24'h000000;
		end else begin
			// Previous SCLK level for edge detection
			sclk_d_r <= i_sclk;
			if (i_cs_n) begin
				bit_cnt_r <= 5'd0;
			end else if (rise) begin
				shift_r <= frame;
				// Saturates so extra clocks cannot wrap into a second write
				if (bit_cnt_r != 5'd31)
					bit_cnt_r <= bit_cnt_r + 5'd1;
			end
		end
	end

	// Read path: data loaded after the address, shifted on falling SCLK
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rd_shift_r <= 8'h00;
			reading_r <= 1'b0;
			o_sdo <= 1'b0;
			o_sdo_oe <= 1'b0;
		end else if (i_cs_n) begin
			reading_r <= 1'b0;
			o_sdo_oe <= 1'b0;
		// Direction bit has reached frame[15] on the 16th rising edge
		end else if (rise && bit_cnt_r == 5'd15 && frame[15]) begin
			reading_r <= 1'b1;
			rd_shift_r <= rd_data;
			o_sdo_oe <= 1'b1;
		end else if (fall && reading_r) begin
			o_sdo <= rd_shift_r[7];
			rd_shift_r <= {rd_shift_r[6:0], 1'b0};
		end
	end

	// Register file; reserved enable bits are forced low
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			enable_r <= `FNSC_RST_ENABLE;
			int_l_r <= `FNSC_RST_INT_L;
			int_h_r <= `FNSC_RST_INT_H;
			frac_l_r <= `FNSC_RST_FRAC_L;
			frac_m_r <= 8'h00;
			frac_h_r <= 8'h00;
			den_l_r <= `FNSC_RST_DEN_L;
			den_m_r <= 8'h00;
			den_h_r <= 8'h00;
			rdiv_l_r <= `FNSC_RST_RDIV_L;
			rdiv_h_r <= 8'h00;
			refcfg_r <= 8'h00;
			muxsel_r <= `FNSC_MUX_LOCK;
			lock_r <= `FNSC_RST_LOCK;
			pump_r <= `FNSC_RST_PUMP;
			bleed_r <= 8'h00;
		end else if (wr) begin
			case (addr)
			`FNSC_A_ENABLE: enable_r <= frame[7:0] & ~`FNSC_ENABLE_RSVD_MASK;
			// Feedback divider words wait here until the low integer byte applies them
			`FNSC_A_INT_L: int_l_r <= frame[7:0];
			`FNSC_A_INT_H: int_h_r <= frame[7:0];
			`FNSC_A_FRAC_L: frac_l_r <= frame[7:0];
			`FNSC_A_FRAC_M: frac_m_r <= frame[7:0];
			`FNSC_A_FRAC_H: frac_h_r <= frame[7:0];
			`FNSC_A_DEN_L: den_l_r <= frame[7:0];
			`FNSC_A_DEN_M: den_m_r <= frame[7:0];
			`FNSC_A_DEN_H: den_h_r <= frame[7:0];
			`FNSC_A_RDIV_L: rdiv_l_r <= frame[7:0];
			`FNSC_A_RDIV_H: rdiv_h_r <= {6'h00, frame[1:0]};
			`FNSC_A_REFCFG: refcfg_r <= {5'h00, frame[2:0]};
			`FNSC_A_MUXSEL: muxsel_r <= frame[7:0];
			`FNSC_A_LOCK: lock_r <= frame[7:0];
			`FNSC_A_PUMP: pump_r <= {4'h0, frame[3:0]};
			`FNSC_A_BLEED: bleed_r <= frame[7:0];
			// Unmapped addresses are ignored
			default: ;
			endcase
		end
	end

	// Floor applied to integer, denominator and reference divider
	function [23:0] at_least;
		input [23:0] v;
		input [23:0] lo;
		begin
			at_least = (v < lo) ? lo : v;
		end
	endfunction

	// Illegal low settings are raised so the loop never sees them
	wire [23:0] int_apply = at_least({8'h00, int_h_r, frame[7:0]}, {8'h00, `FNSC_INT_MIN});
	wire [23:0] den_apply = at_least({den_h_r, den_m_r, den_l_r}, 24'h000001);
	wire [23:0] rdiv_apply = at_least({14'h0, rdiv_h_r[1:0], rdiv_l_r}, 24'h000001);

	// Unbuffered settings follow their registers one clock later
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_block_enable <= `FNSC_RST_ENABLE;
			o_bleed_current_code <= 8'h00;
			o_ref_double <= 1'b0;
			o_ref_half <= 1'b0;
			o_ref_div <= {2'b00, `FNSC_RST_RDIV_L};
		end else begin
			o_block_enable <= enable_r;
			o_bleed_current_code <= bleed_r;
			// Doubler is bit 2, halver bit 0 of the reference config
			o_ref_double <= refcfg_r[2];
			o_ref_half <= refcfg_r[0];
			o_ref_div <= rdiv_apply[9:0];
		end
	end

	// Double-buffered outputs update on low integer write
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_int_value <= {`FNSC_RST_INT_H, `FNSC_RST_INT_L};
			o_frac_value <= {16'h0000, `FNSC_RST_FRAC_L};
			o_divider_denominator <= {16'h0000, `FNSC_RST_DEN_L};
			o_integer_mode <= 1'b0;
			o_pump_current_code <= 4'h3;
			o_autocal_start <= 1'b0;
			post_cnt_r <= 5'd0;
		end else begin
			o_autocal_start <= 1'b0;
			if (wr && addr == `FNSC_A_INT_L) begin
				o_int_value <= int_apply[15:0];
				o_frac_value <= {frac_h_r, frac_m_r, frac_l_r};
				// Integer-only mode when the applied fraction is zero
				o_integer_mode <= {frac_h_r, frac_m_r, frac_l_r} == 24'h000000;
				o_divider_denominator <= den_apply;
				o_pump_current_code <= pump_r[3:0];
				o_autocal_start <= 1'b1;
				// Trailing host clocks are counted only; nothing waits on them
				post_cnt_r <= `FNSC_POST_CLKS;
			end else if (rise && post_cnt_r != 5'd0) begin
				post_cnt_r <= post_cnt_r - 5'd1;
			end
		end
	end

	// Lock counting runs only while some block is enabled
	fnsc_lock_detect #(
		.CNT_W(LOCK_CNT_W),
		.LOCK_COUNT(LOCK_COUNT)
	) u_lock (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_enable(enable_r != 8'h00),
		.i_cmp_tick(i_cmp_tick),
		.i_in_window(i_in_window),
		.o_locked(locked)
	);

	// Unknown select codes drive the pin low
	always @* begin
		case (muxsel_r)
		`FNSC_MUX_LOW: status_nxt = 1'b0;
		`FNSC_MUX_HIGH: status_nxt = 1'b1;
		`FNSC_MUX_LOCK: status_nxt = locked;
		`FNSC_MUX_RCLK: status_nxt = i_ref_clk_div;
		`FNSC_MUX_NCLK: status_nxt = i_fb_clk_div;
		default: status_nxt = 1'b0;
		endcase
	end

	// Registered so a select change cannot glitch the pin
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			o_status_output_pin <= 1'b0;
		else
			o_status_output_pin <= status_nxt;
	end
endmodule

// file: verif/fnsc_host.sv
/* Host model of the serial control port.
 Assumes the device samples on SCLK rise and shifts read data on SCLK fall. */
`timescale 1ns/1ns
module fnsc_host (
	input wire logic i_clk,
	input wire logic i_sdo,
	output logic o_sclk = 1'b0,
	output logic o_sdi = 1'b0,
	output logic o_cs_n = 1'b1
);
	int half = 3;
	// Several clocks per phase, since the port oversamples SCLK
	task automatic xfer(input logic [23:0] f, input int n, output logic [7:0] rd);
		rd = 8'h00;
		o_cs_n <= 1'b0;
		for (int i = 0; i < n; i++) begin
			o_sdi <= f[23 - i];
			o_sclk <= 1'b0;
			repeat (half) @(posedge i_clk);
			o_sclk <= 1'b1;
			repeat (half) @(posedge i_clk);
			if (i > 15)
				rd = {rd[6:0], i_sdo};
		end
		o_sclk <= 1'b0;
		repeat (half) @(posedge i_clk);
		o_cs_n <= 1'b1;
		o_sdi <= ~o_sdi;
		repeat (half) @(posedge i_clk);
	endtask
endmodule

// file: verif/fnsc_top_chk.sv
/* Assertion checker of the control port top.
 Assumes one clock domain; attached by bind. */
`timescale 1ns/1ns
module fnsc_top_chk (
	input wire i_clk,
	input wire i_rst,
	input wire i_sclk,
	input wire i_cs_n,
	input wire o_sdo,
	input wire o_sdo_oe,
	input wire [23:0] o_frac_value,
	input wire [23:0] o_divider_denominator,
	input wire o_integer_mode,
	input wire [7:0] o_bleed_current_code,
	input wire [7:0] o_block_enable,
	input wire o_autocal_start
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_oe_cs_high: assert property ($past(i_cs_n) && i_cs_n |-> !o_sdo_oe)
		else $error("sdo driven while deselected");
	a_den_nonzero: assert property (o_divider_denominator != 24'h0)
		else $error("zero denominator");
	a_int_mode: assert property ($stable(o_frac_value) |-> o_integer_mode == ~|o_frac_value)
		else $error("integer mode wrong");
	a_rsvd_enable: assert property ((o_block_enable & 8'h90) == 8'h00)
		else $error("reserved enable bit set");
	a_cal_pulse: assert property (o_autocal_start |=> !o_autocal_start)
		else $error("calibration pulse too long");
	a_sdo_on_fall: assert property (o_sdo_oe && $changed(o_sdo) |-> !i_sclk)
		else $error("sdo moved with sclk high");
	a_frac_with_cal: assert property ($changed(o_frac_value) |->
		o_autocal_start || $past(o_autocal_start) || $past(o_autocal_start, 2))
		else $error("fraction applied without calibration");
	a_bleed_in_frame: assert property ($changed(o_bleed_current_code) |-> !$past(i_cs_n))
		else $error("bleed changed outside a frame");
endmodule
bind fnsc_top fnsc_top_chk chk_u (.i_clk, .i_rst, .i_sclk, .i_cs_n, .o_sdo, .o_sdo_oe,
	.o_frac_value, .o_divider_denominator, .o_integer_mode, .o_bleed_current_code,
	.o_block_enable, .o_autocal_start);

// file: verif/fnsc_top_tb.sv
/* Self-checking bench of the control port: random and corner frames.
 Assumes the host model drives the serial pins and the checker is bound. */
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
	$display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module fnsc_top_tb;
	logic i_clk = 1'b0, i_rst = 1'b1, i_cmp_tick = 1'b0, i_in_window = 1'b0;
	logic i_ref_clk_div = 1'b1, i_fb_clk_div = 1'b0;
	wire i_sclk, i_sdi, i_cs_n, o_sdo, o_sdo_oe, o_status_output_pin, o_integer_mode;
	wire o_ref_double, o_ref_half, o_autocal_start;
	wire [15:0] o_int_value;
	wire [23:0] o_frac_value, o_divider_denominator;
	wire [9:0] o_ref_div;
	wire [3:0] o_pump_current_code;
	wire [7:0] o_bleed_current_code, o_block_enable;
	int errors = 0, n_tests = 0;
	logic [31:0] seed = 32'd23120;
	logic [7:0] rd, v;
	logic [15:0] n;
	logic [23:0] f, d, ef = 24'h2;
	fnsc_top #(.LOCK_COUNT(16)) dut_u (.*);
	// A released line reads as the inverse, so a missing output enable shows up
	fnsc_host host_u (.i_clk, .i_sdo(o_sdo_oe ? o_sdo : ~o_sdo), .o_sclk(i_sclk),
		.o_sdi(i_sdi), .o_cs_n(i_cs_n));
	initial forever #5 i_clk = ~i_clk;
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function automatic logic [15:0] exp_int(input logic [15:0] x);
		return (x < 16'h004b) ? 16'h004b : x;
	endfunction
	// Recommended bleed: 4 * pump current / N, rounded to 3.75 uA steps
	function automatic logic [7:0] pick_bleed(input int cp, input int nn);
		return 8'((2 * (cp + 1) * 1000 + 3 * nn) / (6 * nn));
	endfunction
	task automatic wr(input logic [14:0] a, input logic [7:0] x);
		host_u.xfer({1'b0, a, x}, 24, rd);
	endtask
	task automatic rdchk(input logic [14:0] a, input logic [7:0] e);
		host_u.xfer({1'b1, a, 8'h00}, 24, rd);
		`CHK(rd, e)
	endtask
	task automatic ticks(input int k, input logic w);
		repeat (k) begin
			i_cmp_tick <= 1'b1;
			i_in_window <= w;
			@(posedge i_clk);
			i_cmp_tick <= 1'b0;
			repeat (3) @(posedge i_clk);
		end
	endtask
	task give_verdict();
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#900000;
		errors++;
		give_verdict();
	end
	initial begin
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		`CHK({o_pump_current_code, o_int_value, o_frac_value}, {4'h3, 16'h00a7, 24'h2})
		`CHK({o_divider_denominator, o_block_enable}, {24'h4, 8'h6f})
		rdchk(15'h022e, 8'h03);
		rdchk(15'h0105, 8'h00);
		for (int i = 0; i < 6; i++) begin
			host_u.half = (i == 1) ? 6 : 3;
			v = (i == 0) ? 8'hff : (i == 2) ? pick_bleed(3, 167) : rnd();
			wr(15'h022f, v);
			`CHK(o_bleed_current_code, v)
			rdchk(15'h022f, v);
			host_u.xfer({1'b0, 15'h022f, ~v}, 20, rd);
			`CHK(o_bleed_current_code, v)
		end
		for (int i = 0; i < 5; i++) begin
			f = (i == 0) ? 24'h0 : {rnd(), rnd(), rnd()};
			d = (i == 1) ? 24'h0 : {rnd(), rnd(), rnd()};
			n = (i == 2) ? 16'h004a : (i == 3) ? 16'h004b : {rnd(), rnd()};
			v = rnd() & 8'h0f;
			wr(15'h022e, v);
			for (int b = 2; b >= 0; b--) begin
				wr(15'h0202 + 15'(b), f[8 * b +: 8]);
				wr(15'h0208 + 15'(b), d[8 * b +: 8]);
			end
			wr(15'h0201, n[15:8]);
			`CHK(o_frac_value, ef)
			wr(15'h0200, n[7:0]);
			ef = f;
			`CHK({o_frac_value, o_integer_mode, o_pump_current_code}, {f, f == 24'h0, v[3:0]})
			`CHK(o_divider_denominator, (d == 24'h0) ? 24'h1 : d)
			`CHK(o_int_value, exp_int(n))
		end
		for (int i = 0; i < 3; i++) begin
			v = (i == 0) ? 8'h00 : (i == 1) ? rnd() : 8'h6f;
			wr(15'h0103, v);
			`CHK(o_block_enable, v & 8'h6f)
		end
		for (int i = 0; i < 3; i++) begin
			d = (i == 0) ? 24'h0 : {rnd(), rnd(), rnd()};
			wr(15'h020c, d[7:0]);
			wr(15'h020d, d[15:8]);
			wr(15'h020e, d[23:16]);
			`CHK(o_ref_div, (d[9:0] == 10'h0) ? 10'h1 : d[9:0])
			`CHK({o_ref_double, o_ref_half}, {d[18], d[16]})
		end
		for (int m = 0; m < 6; m++) begin
			i_fb_clk_div <= (m == 4);
			wr(15'h0213, m[7:0]);
			`CHK(o_status_output_pin, 1'(m == 1 || m == 3 || m == 4))
		end
		wr(15'h0213, 8'h02);
		for (int k = 0; k < 2; k++) begin
			ticks(15, 1'b1);
			`CHK(o_status_output_pin, 1'b0)
			ticks(1, 1'b1);
			`CHK(o_status_output_pin, 1'b1)
			ticks(1, 1'b0);
			`CHK(o_status_output_pin, 1'b0)
		end
		give_verdict();
	end
endmodule
